// file: core/aocr_output_config.v
/*
 output configuration register group of a multi-channel converter:
 test pattern select, output format, clock phase adjust, offset trim and
 reference span select, plus the data path these registers steer.
 assumes a serial control port front end that hands over decoded byte
 writes and reads on the sample clock, and raw two's complement samples.
*/
`timescale 1ns/100ps
`include "aocr_map.vh"

module aocr_output_config #(
   parameter WIDTH = 14
) (
   // clock and reset
   mclk,
   rst_n,
   // register access from control port
   reg_addr,
   reg_wr,
   reg_wdata,
   reg_rd,
   reg_rdata,
   // conversion data path
   adc_sample,
   out_data,
   // settings to analog and clocking sections
   out_clk_phase,
   span_sel,
   offset_trim,
   lvds_reduced,
   drive_double,
   termination
);
   input  wire             mclk;          // sample clock
   input  wire             rst_n;         // async reset, active low
   input  wire [7:0]       reg_addr;      // register offset
   input  wire             reg_wr;        // write strobe, one cycle
   input  wire [7:0]       reg_wdata;     // write data
   input  wire             reg_rd;        // read strobe, one cycle
   output reg  [7:0]       reg_rdata;     // read data, registered
   input  wire [WIDTH-1:0] adc_sample;    // raw sample, twos complement
   output reg  [WIDTH-1:0] out_data;      // word to serialiser
   output wire [3:0]       out_clk_phase; // divider phase for output clock
   output wire [2:0]       span_sel;      // reference full scale code
   output wire [7:0]       offset_trim;   // offset trim word
   output wire             lvds_reduced;  // reduced swing option
   output wire             drive_double;  // 2x drive option
   output wire [1:0]       termination;   // termination select

   // ========================================================================
   // register storage
   reg [7:0] offset_trim_reg;      // offset trim
   reg [7:0] format_ctrl_reg;      // output format control
   reg [7:0] driver_adj_reg;       // output driver adjust
   reg [7:0] phase_adj_reg;        // clock phase adjust
   reg [7:0] span_sel_reg;         // reference span select
   reg [7:0] test_mode_reg;        // test pattern select (low nibble)
   reg [7:0] rdata_next;           // read mux
   reg       toggle_reg;           // alternates each sample for checker and word toggle
   reg [WIDTH-1:0] out_next;       // next output word
   wire [WIDTH-1:0] delayed;       // phase-delayed sample
   wire [WIDTH-1:0] fmt_sample;    // sample after format
   wire [3:0] wr_out_phase;        // written output phase field
   wire [2:0] wr_span;             // written span field

   assign wr_out_phase = reg_wdata[`AOCR_OUT_PHASE_HI:`AOCR_OUT_PHASE_LO];
   assign wr_span      = reg_wdata[`AOCR_SPAN_HI:`AOCR_SPAN_LO];

   // ========================================================================
   // register writes; only documented bits are kept so open bits read zero
   // a read in the same cycle as a write returns the old contents, since
   // the read mux below looks at the registers before this edge lands
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         offset_trim_reg <= `AOCR_RST_OFFSET_TRIM;
         format_ctrl_reg <= `AOCR_RST_FORMAT_CTRL;
         driver_adj_reg  <= `AOCR_RST_DRIVER_ADJ;
         phase_adj_reg   <= `AOCR_RST_PHASE_ADJ;
         span_sel_reg    <= `AOCR_RST_SPAN_SEL;
         test_mode_reg   <= `AOCR_RST_TEST_MODE;
      end else if (reg_wr) begin
         if (reg_addr == `AOCR_OFS_OFFSET_TRIM) begin
            offset_trim_reg <= reg_wdata & `AOCR_MSK_OFFSET_TRIM;
         end else if (reg_addr == `AOCR_OFS_FORMAT_CTRL) begin
            format_ctrl_reg <= reg_wdata & `AOCR_MSK_FORMAT_CTRL;
         end else if (reg_addr == `AOCR_OFS_DRIVER_ADJ) begin
            driver_adj_reg  <= reg_wdata & `AOCR_MSK_DRIVER_ADJ;
         end else if (reg_addr == `AOCR_OFS_PHASE_ADJ) begin
            // whole write refused when output phase is out of range,
            // so the phase field never holds an illegal divider tap
            if (wr_out_phase <= `AOCR_OUT_PHASE_MAX) begin
               phase_adj_reg <= reg_wdata & `AOCR_MSK_PHASE_ADJ;
            end
         end else if (reg_addr == `AOCR_OFS_SPAN_SEL) begin
            // codes above 100 have no span; write ignored
            if (wr_span <= `AOCR_SPAN_MAX) begin
               span_sel_reg <= reg_wdata & `AOCR_MSK_SPAN_SEL;
            end
         end else if (reg_addr == `AOCR_OFS_TEST_MODE) begin
            test_mode_reg <= reg_wdata & `AOCR_MSK_TEST_MODE;
         end
      end
   end

   // ========================================================================
   // read mux; unmapped offsets read zero
   always @* begin
      rdata_next = 8'h00;
      if (reg_addr == `AOCR_OFS_OFFSET_TRIM) begin
         rdata_next = offset_trim_reg;
      end else if (reg_addr == `AOCR_OFS_FORMAT_CTRL) begin
         rdata_next = format_ctrl_reg;
      end else if (reg_addr == `AOCR_OFS_DRIVER_ADJ) begin
         rdata_next = driver_adj_reg;
      end else if (reg_addr == `AOCR_OFS_PHASE_ADJ) begin
         rdata_next = phase_adj_reg;
      end else if (reg_addr == `AOCR_OFS_SPAN_SEL) begin
         rdata_next = span_sel_reg;
      end else if (reg_addr == `AOCR_OFS_TEST_MODE) begin
         rdata_next = test_mode_reg;
      end
   end

   // read data held until the next read strobe
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_next;
      end
   end

   // ========================================================================
   // input clock phase: sample taken N whole cycles late
   aocr_delay_mem #(
      .WIDTH (WIDTH),
      .DEPTH (`AOCR_DELAY_DEPTH)
   ) u_delay (
      .mclk  (mclk),
      .rst_n (rst_n),
      .din   (adc_sample),
      .tap   (phase_adj_reg[`AOCR_IN_PHASE_HI:`AOCR_IN_PHASE_LO]),
      .dout  (delayed)
   );

   // ========================================================================
   // format: offset binary flips the sign bit; invert complements all
   assign fmt_sample =
      (format_ctrl_reg[`AOCR_FMT_TWOS_BIT] ? delayed :
       {~delayed[WIDTH-1], delayed[WIDTH-2:0]}) ^
      {WIDTH{format_ctrl_reg[`AOCR_FMT_INVERT_BIT]}};

   // alternation source for the checker and word toggle patterns
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         toggle_reg <= 1'b0;
      end else begin
         toggle_reg <= ~toggle_reg;
      end
   end

   // ========================================================================
   // output word select; unhandled pattern codes fall back to data
   // pattern words are fixed bit images, so output format and invert do
   // not touch them; the midscale word is the offset binary midpoint
   always @* begin
      out_next = fmt_sample;
      case (test_mode_reg[`AOCR_TEST_HI:`AOCR_TEST_LO])
         `AOCR_TEST_OFF: begin
            out_next = fmt_sample;
         end
         `AOCR_TEST_MIDSCALE: begin
            out_next = {1'b1, {(WIDTH-1){1'b0}}};
         end
         `AOCR_TEST_POS_FS: begin
            out_next = {WIDTH{1'b1}};
         end
         `AOCR_TEST_NEG_FS: begin
            out_next = {WIDTH{1'b0}};
         end
         `AOCR_TEST_CHECKER: begin
            out_next = {(WIDTH/2){toggle_reg, ~toggle_reg}};
         end
         `AOCR_TEST_WORD_TOGGLE: begin
            out_next = {WIDTH{toggle_reg}};
         end
         `AOCR_TEST_BIT_TOGGLE: begin
            out_next = {(WIDTH/2){2'b10}};
         end
         default: begin
            out_next = fmt_sample;
         end
      endcase
   end

   // output word register
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_data <= {WIDTH{1'b0}};
      end else begin
         out_data <= out_next;
      end
   end

   // ========================================================================
   // settings out; output phase only steers the output clock divider tap,
   // data latching above stays on mclk whatever it holds
   assign out_clk_phase =
      phase_adj_reg[`AOCR_OUT_PHASE_HI:`AOCR_OUT_PHASE_LO];
   assign span_sel     = span_sel_reg[`AOCR_SPAN_HI:`AOCR_SPAN_LO];
   assign offset_trim  = offset_trim_reg;
   // electrical options are only stored and passed on; the pads that act
   // on them sit outside this block
   assign lvds_reduced = format_ctrl_reg[`AOCR_FMT_SWING_BIT];
   assign drive_double = driver_adj_reg[`AOCR_DRV_DOUBLE_BIT];
   assign termination  = driver_adj_reg[`AOCR_TERM_HI:`AOCR_TERM_LO];

endmodule // aocr_output_config

// file: common/aocr_map.vh
/*
 register offsets, field positions, reset values and timing counts of the
 converter output configuration register group.
 assumes inclusion by bare name from design files of this block.
*/
`ifndef AOCR_MAP_VH
`define AOCR_MAP_VH

// ==========================================================================
// register offsets (control port address space)
`define AOCR_OFS_OFFSET_TRIM      8'h10
`define AOCR_OFS_FORMAT_CTRL      8'h14
`define AOCR_OFS_DRIVER_ADJ       8'h15
`define AOCR_OFS_PHASE_ADJ        8'h16
`define AOCR_OFS_SPAN_SEL         8'h18
`define AOCR_OFS_TEST_MODE        8'h0D

// ==========================================================================
// reset values
`define AOCR_RST_OFFSET_TRIM      8'h00
`define AOCR_RST_FORMAT_CTRL      8'h01
`define AOCR_RST_DRIVER_ADJ       8'h00
`define AOCR_RST_PHASE_ADJ        8'h03
`define AOCR_RST_SPAN_SEL         8'h04
`define AOCR_RST_TEST_MODE        8'h00

// ==========================================================================
// writable bit masks (open bits read zero)
`define AOCR_MSK_OFFSET_TRIM      8'hFF
`define AOCR_MSK_FORMAT_CTRL      8'h45
`define AOCR_MSK_DRIVER_ADJ       8'h31
`define AOCR_MSK_PHASE_ADJ        8'h7F
`define AOCR_MSK_SPAN_SEL         8'h07
`define AOCR_MSK_TEST_MODE        8'h0F

// ==========================================================================
// field positions
`define AOCR_FMT_TWOS_BIT         0
`define AOCR_FMT_INVERT_BIT       2
`define AOCR_FMT_SWING_BIT        6
`define AOCR_DRV_DOUBLE_BIT       0
`define AOCR_TERM_HI              5
`define AOCR_TERM_LO              4
`define AOCR_IN_PHASE_HI          6
`define AOCR_IN_PHASE_LO          4
`define AOCR_OUT_PHASE_HI         3
`define AOCR_OUT_PHASE_LO         0
`define AOCR_OUT_PHASE_MAX        4'hB
`define AOCR_SPAN_HI              2
`define AOCR_SPAN_LO              0
`define AOCR_SPAN_MAX             3'h4
`define AOCR_TEST_HI              3
`define AOCR_TEST_LO              0

// ==========================================================================
// test pattern codes handled here
`define AOCR_TEST_OFF             4'h0
`define AOCR_TEST_MIDSCALE        4'h1
`define AOCR_TEST_POS_FS          4'h2
`define AOCR_TEST_NEG_FS          4'h3
`define AOCR_TEST_CHECKER         4'h4
`define AOCR_TEST_WORD_TOGGLE     4'h7
`define AOCR_TEST_BIT_TOGGLE      4'h9

// ==========================================================================
// timing: depth of the sample delay line (max input phase); tap 0 reads
// the live input, so a phase of 7 needs only seven stored entries
`define AOCR_DELAY_DEPTH          7

`endif

// file: core/aocr_delay_mem.v
/*
 small shift memory holding recent samples; read data come out of a
 register, selected by a programmable tap (whole sample clock delay).
 assumes one clock domain, tap changes only from the register bank.
*/
`timescale 1ns/100ps
`include "aocr_map.vh"

module aocr_delay_mem #(
   parameter WIDTH = 14,
   parameter DEPTH = `AOCR_DELAY_DEPTH
) (
   // clock and reset
   mclk,
   rst_n,
   // sample stream
   din,
   tap,
   dout
);
   input  wire             mclk;   // sample clock
   input  wire             rst_n;  // async reset, active low
   input  wire [WIDTH-1:0] din;    // incoming sample
   input  wire [2:0]       tap;    // delay in whole cycles
   output reg  [WIDTH-1:0] dout;   // registered delayed sample

   reg [WIDTH-1:0] mem_reg [0:DEPTH-1]; // delay line entries

   // ========================================================================
   // delay line: entry 0 is the freshest sample
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_stage
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               mem_reg[gi] <= {WIDTH{1'b0}};
            end else if (gi == 0) begin
               mem_reg[gi] <= din;
            end else begin
               mem_reg[gi] <= mem_reg[(gi == 0) ? 0 : gi-1];
            end
         end
      end
   endgenerate

   // ========================================================================
   // tap 0 reads the fresh input so zero delay adds nothing beyond dout
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dout <= {WIDTH{1'b0}};
      end else if (tap == 3'h0) begin
         dout <= din;
      end else begin
         dout <= mem_reg[tap - 3'h1];
      end
   end

endmodule // aocr_delay_mem

// file: verification/aocr_output_config_asserts.sv
/*
 port checker of the output configuration register group.
 assumes binding to aocr_output_config, one sample clock, async low reset.
*/
`timescale 1ns/100ps
// ==========================================================================
// checker
module aocr_output_config_asserts #(
   parameter WIDTH = 14
) (
   // clock and reset
   input wire             mclk,
   input wire             rst_n,
   // register access
   input wire [7:0]       reg_addr,
   input wire             reg_wr,
   input wire [7:0]       reg_wdata,
   input wire             reg_rd,
   input wire [7:0]       reg_rdata,
   // data path
   input wire [WIDTH-1:0] adc_sample,
   input wire [WIDTH-1:0] out_data,
   // settings
   input wire [3:0]       out_clk_phase,
   input wire [2:0]       span_sel,
   input wire [7:0]       offset_trim,
   input wire             lvds_reduced,
   input wire             drive_double,
   input wire [1:0]       termination
);
   localparam [WIDTH-1:0] MID = {1'b1, {(WIDTH-1){1'b0}}}; // midscale word
   // write decodes per register
   wire w_ph = reg_wr && reg_addr == 8'h16;
   wire w_sp = reg_wr && reg_addr == 8'h18;
   wire w_tm = reg_wr && reg_addr == 8'h0D;
   // any address outside the group reads zero
   wire mapped = reg_addr == 8'h10 || reg_addr == 8'h14 ||
                 reg_addr == 8'h15 || reg_addr == 8'h16 ||
                 reg_addr == 8'h18 || reg_addr == 8'h0D;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_ph_take;
      w_ph && reg_wdata[3:0] <= 4'hB |=>
         out_clk_phase == $past(reg_wdata[3:0]);
   endproperty
   a_ph_take: assert property (p_ph_take) else $error("phase lost");
   property p_ph_refuse;
      w_ph && reg_wdata[3:0] > 4'hB |=> $stable(out_clk_phase);
   endproperty
   a_ph_refuse: assert property (p_ph_refuse) else $error("bad phase");
   property p_sp_take;
      w_sp && reg_wdata[2:0] <= 3'h4 |=> span_sel == $past(reg_wdata[2:0]);
   endproperty
   a_sp_take: assert property (p_sp_take) else $error("span not taken");
   property p_sp_refuse;
      w_sp && reg_wdata[2:0] > 3'h4 |=> $stable(span_sel);
   endproperty
   a_sp_refuse: assert property (p_sp_refuse) else $error("bad span");
   property p_trim;
      reg_wr && reg_addr == 8'h10 |=> offset_trim == $past(reg_wdata);
   endproperty
   a_trim: assert property (p_trim) else $error("trim not taken");
   property p_drv;
      reg_wr && reg_addr == 8'h15 |=> drive_double == $past(reg_wdata[0])
         && termination == $past(reg_wdata[5:4]);
   endproperty
   a_drv: assert property (p_drv) else $error("driver bits wrong");
   property p_lvds;
      reg_wr && reg_addr == 8'h14 |=> lvds_reduced == $past(reg_wdata[6]);
   endproperty
   a_lvds: assert property (p_lvds) else $error("swing bit wrong");
   property p_unmap;
      reg_rd && !mapped |=> reg_rdata == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_mid;
      w_tm && reg_wdata[3:0] == 4'h1 ##1 !w_tm |=> out_data == MID;
   endproperty
   a_mid: assert property (p_mid) else $error("midscale missing");
endmodule // aocr_output_config_asserts

// file: verification/aocr_output_config_tb_top.sv
/*
 self-checking bench of the output configuration register group.
 assumes the design and its checker compiled alongside; drives at negedge.
*/
`timescale 1ns/100ps
// ==========================================================================
// bench
module aocr_output_config_tb_top;
   reg         mclk, rst_n, reg_wr, reg_rd;
   reg  [7:0]  reg_addr, reg_wdata, e;
   reg  [13:0] adc_sample, o1;
   wire [7:0]  reg_rdata, offset_trim;
   wire [13:0] out_data;
   wire [3:0]  out_clk_phase;
   wire [2:0]  span_sel;
   wire        lvds_reduced, drive_double;
   wire [1:0]  termination;
   integer     errors, compares, cyc, i;
   reg  [27:0] codes = 28'h1239470;           // test codes in run order
   reg  [63:0] pats = 64'h20003FFF00002AAA;   // fixed words for first four
   aocr_output_config #(.WIDTH(14)) dut_u (.mclk(mclk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_sample(adc_sample),
      .out_data(out_data), .out_clk_phase(out_clk_phase),
      .span_sel(span_sel), .offset_trim(offset_trim),
      .lvds_reduced(lvds_reduced), .drive_double(drive_double),
      .termination(termination));
   // one comparison; a mismatch prints both values in hex
   task chk(input [15:0] seen, input [15:0] exp);
      compares = compares + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask
   // one write strobe, released a cycle later
   task wr(input [7:0] a, input [7:0] d);
      @(negedge mclk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge mclk);
      reg_wr    = 1'b0;
   endtask
   // one read strobe, data judged once registered
   task rd(input [7:0] a, input [7:0] exp);
      @(negedge mclk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge mclk);
      reg_rd   = 1'b0;
      chk(reg_rdata, exp);
   endtask
   // counts, verdict and the end of the run
   task end_of_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // reset values of every register, the phase and span settings and the output word
   task t_reset;
      chk(out_clk_phase, 4'h3);
      chk(span_sel, 3'h4);
      chk(out_data, 14'h0000);
      rd(8'h10, 8'h00);
      rd(8'h14, 8'h01);
      rd(8'h15, 8'h00);
      rd(8'h16, 8'h03);
      rd(8'h18, 8'h04);
      rd(8'h0D, 8'h00);
      $display("test reset done");
   endtask
   // open bits read zero, unmapped space reads zero
   task t_mask;
      wr(8'h10, 8'h5A);
      rd(8'h10, 8'h5A);
      chk(offset_trim, 8'h5A);
      wr(8'h10, 8'hFF);
      wr(8'h14, 8'hFF);
      wr(8'h15, 8'hFF);
      wr(8'h11, 8'hFF);
      rd(8'h10, 8'hFF);
      rd(8'h14, 8'h45);
      rd(8'h15, 8'h31);
      rd(8'h11, 8'h00);
      chk(drive_double, 1'b1);
      chk(termination, 2'h3);
      chk(lvds_reduced, 1'b1);
      chk(offset_trim, 8'hFF);
      $display("test mask done");
   endtask
   // every phase and span code; out of range ones leave the old value
   task t_range;
      e = 8'h03;
      for (i = 0; i < 16; i = i + 1) begin
         wr(8'h16, i[7:0]);
         if (i <= 11) begin
            e = i[7:0];
         end
         rd(8'h16, e);
         chk(out_clk_phase, e[3:0]);
      end
      e = 8'h04;
      for (i = 0; i < 8; i = i + 1) begin
         wr(8'h18, i[7:0]);
         if (i <= 4) begin
            e = i[7:0];
         end
         rd(8'h18, e);
         chk(span_sel, e[2:0]);
      end
      $display("test range done");
   endtask
   // step the sample and find it exactly 2+n cycles later
   task t_path(input [2:0] n, input [7:0] fmt);
      wr(8'h14, fmt);
      wr(8'h16, {1'b0, n, 4'h3});
      // offset binary flips the sign bit, invert flips every bit
      o1 = (fmt[0] ? 14'h0000 : 14'h2000) ^ (fmt[2] ? 14'h3FFF : 14'h0000);
      adc_sample = 14'h0123;
      repeat (12) @(negedge mclk);
      adc_sample = 14'h2ABC;
      // one cycle before the new word is due the old one still shows
      repeat (n + 1) @(negedge mclk);
      chk(out_data, 14'h0123 ^ o1);
      @(negedge mclk);
      chk(out_data, 14'h2ABC ^ o1);
      $display("test path done");
   endtask
   // each pattern code in turn, then back to conversion data
   task t_test;
      wr(8'h16, 8'h03);
      wr(8'h14, 8'h01);
      for (i = 0; i < 7; i = i + 1) begin
         wr(8'h0D, {4'h0, codes[27 - 4 * i -: 4]});
         repeat (2) @(negedge mclk);
         o1 = out_data;
         if (i < 4) begin
            chk(o1, pats[63 - 16 * i -: 16]);
         end else if (i == 6) begin
            chk(o1, adc_sample);
         end else begin
            // the word itself, then its inverse on the next sample
            chk(o1 ^ {14{o1[0]}}, (i == 4) ? 14'h2AAA : 14'h0000);
            @(negedge mclk);
            chk(out_data ^ o1, 14'h3FFF);
         end
      end
      $display("test pattern done");
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // hang guard
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         errors = errors + 1;
         end_of_test;
      end
   end
   // reset for 8 cycles, then the scenarios in turn
   initial begin
      errors     = 0;
      compares   = 0;
      cyc        = 0;
      rst_n      = 1'b0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      reg_addr   = 8'h00;
      reg_wdata  = 8'h00;
      adc_sample = 14'h0000;
      repeat (8) @(negedge mclk);
      rst_n = 1'b1;
      t_reset;
      t_mask;
      t_range;
      t_path(3'd0, 8'h01);
      t_path(3'd7, 8'h00);
      t_path(3'd3, 8'h01);
      t_path(3'd1, 8'h04);
      t_test;
      end_of_test;
   end
endmodule // aocr_output_config_tb_top
bind aocr_output_config aocr_output_config_asserts #(.WIDTH(WIDTH)) chk_u (
   .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .adc_sample(adc_sample), .out_data(out_data),
   .out_clk_phase(out_clk_phase), .span_sel(span_sel),
   .offset_trim(offset_trim), .lvds_reduced(lvds_reduced),
   .drive_double(drive_double), .termination(termination));
